// ---- ahs_axis_model.sv ----
// Purpose: behavioural axis with limit switches, home switch and encoder index
// Assumes: one step of travel per clock while the move command is high
// Notes:   switch and index levels follow the axis position, never left floating
`timescale 1ns/10ps
module ahs_axis_model
(
    // clock
    input  wire logic clk_i,
    // drive command
    input  wire logic move_i,
    input  wire logic dir_pos_i,
    // switches and index
    output logic      limit_neg_o,
    output logic      limit_pos_o,
    output logic      home_switch_o,
    output logic      index_o
);
    // ************************************************
    // travel geometry
    // ************************************************
    localparam int NEG_END     = 0;
    localparam int POS_END     = 200;
    localparam int HOME_LO     = 100;
    localparam int HOME_HI     = 115;
    localparam int INDEX_EVERY = 16;
    localparam int INDEX_AT    = 8;

    int pos;
    int last_index;

    // places the axis while the sequencer is idle
    task place(input int p);
        pos = p;
    endtask : place

    initial begin
        pos        = 50;
        last_index = 0;
    end

    always @(posedge clk_i) begin
        if (move_i) begin
            pos <= dir_pos_i ? pos + 1 : pos - 1;
        end
    end

    assign limit_neg_o   = (pos <= NEG_END);
    assign limit_pos_o   = (pos >= POS_END);
    assign home_switch_o = (pos >= HOME_LO) && (pos <= HOME_HI);
    assign index_o       = ((((pos % INDEX_EVERY) + INDEX_EVERY) % INDEX_EVERY) == INDEX_AT);

    // remembers where the latest index edge was seen
    always @(posedge index_o) begin
        last_index = pos;
    end
endmodule : ahs_axis_model

// ---- ahs_pkg.sv ----
// Purpose: shared constants and types of the axis homing sequencer
// Assumes: one 40 MHz clock, all inputs synchronous to it
// Notes:   modes 1 to 4 only; other mode numbers are refused
// Behaviour
// R01: mode 1, negative limit off at start: move negative at fast speed.
// R02: mode 1, negative limit reached during fast move: reverse, continue slow.
// R03: mode 1, negative limit on at start: move positive at slow speed.
// R04: mode 1, home is first index with negative limit off in slow move.
// R05: mode 2, positive limit off at start: move positive at fast speed.
// R06: mode 2, positive limit reached: reverse, continue at slow speed.
// R07: mode 2, positive limit on at start: move negative at slow speed.
// R08: mode 2, home is first index with positive limit off in slow move.
// R09: mode 3, switch off: positive fast; switch on: reverse at slow speed.
// R10: mode 3, after reversal home is first index with switch off.
// R11: mode 3, switch on at start: negative slow; first index after switch off.
// R12: mode 4, switch off: positive fast; switch on: slow, same direction, next index.
// R13: mode 4, switch on: negative slow; switch off: reverse, slow, next index.
// R14: mode number and speeds sampled at command, held until homing ends.
// R15: on home index stop motion, load position, pulse homing complete.
package ahs_pkg;

    // ************************************************
    // widths
    // ************************************************
    localparam int SPEED_W = 16;
    localparam int POS_W   = 32;
    localparam int MODE_W  = 4;

    // ************************************************
    // mode numbers
    // ************************************************
    localparam logic [MODE_W-1:0] MODE_NEG_LIMIT = 4'h1;
    localparam logic [MODE_W-1:0] MODE_POS_LIMIT = 4'h2;
    localparam logic [MODE_W-1:0] MODE_SW_REV    = 4'h3;
    localparam logic [MODE_W-1:0] MODE_SW_SLOW   = 4'h4;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [MODE_W-1:0]  MODE_RST  = 4'h0;
    localparam logic [SPEED_W-1:0] SPEED_RST = 16'h0000;
    localparam logic [POS_W-1:0]   POS_RST   = 32'h00000000;

    // ************************************************
    // sequencer states
    // ************************************************
    typedef enum logic [2:0] {
        AHS_IDLE = 3'b001,
        AHS_FAST = 3'b010,
        AHS_SLOW = 3'b100
    } ahs_state_t;

endpackage : ahs_pkg

// ---- ahs_sense.sv ----
// Purpose: registers switch levels and finds the rising edge of the index pulse
// Assumes: inputs synchronous to clk_i
// Notes:   one cycle of latency on every signal
`timescale 1ns/10ps
module ahs_sense
    import ahs_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // pins
    input  wire logic limit_neg_i,
    input  wire logic limit_pos_i,
    input  wire logic home_switch_i,
    input  wire logic index_i,
    // to sequencer
    ahs_sense_if.sense sns
);

    typedef struct packed {
        logic lim_neg;
        logic lim_pos;
        logic home_sw;
        logic index;
        logic rise;
    } ahs_sense_state_t;

    ahs_sense_state_t q;
    ahs_sense_state_t next_q;

    always_comb begin
        next_q         = q;
        next_q.lim_neg = limit_neg_i;
        next_q.lim_pos = limit_pos_i;
        next_q.home_sw = home_switch_i;
        next_q.index   = index_i;
        next_q.rise    = index_i & ~q.index;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign sns.lim_neg    = q.lim_neg;
    assign sns.lim_pos    = q.lim_pos;
    assign sns.home_sw    = q.home_sw;
    assign sns.index_rise = q.rise;

endmodule : ahs_sense

// ---- ahs_sense_if.sv ----
// Purpose: conditioned switch and index signals between sensing and sequencing
// Assumes: one clock domain
// Notes:   index_rise is a one-cycle pulse
`timescale 1ns/10ps
interface ahs_sense_if;
    logic lim_neg;
    logic lim_pos;
    logic home_sw;
    logic index_rise;

    modport sense (output lim_neg, output lim_pos, output home_sw, output index_rise);
    modport seq   (input lim_neg, input lim_pos, input home_sw, input index_rise);
endinterface : ahs_sense_if

// ---- axis_homing_sequencer.sv ----
// Purpose: homing sequencer for one axis, modes 1 to 4
// Assumes: inputs synchronous to clk_i; switches active high
// Notes:   command taken only while idle; unknown mode gives a refused pulse
`timescale 1ns/10ps
module axis_homing_sequencer
    import ahs_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    // command and configuration
    input  wire logic               homing_command_i,
    input  wire logic [MODE_W-1:0]  mode_i,
    input  wire logic [SPEED_W-1:0] speed_fast_i,
    input  wire logic [SPEED_W-1:0] speed_slow_i,
    input  wire logic [POS_W-1:0]   home_position_i,
    // switches and encoder index
    input  wire logic               limit_neg_i,
    input  wire logic               limit_pos_i,
    input  wire logic               home_switch_i,
    input  wire logic               index_i,
    // drive command
    output logic                    move_o,
    output logic                    dir_pos_o,
    output logic [SPEED_W-1:0]      speed_o,
    // status
    output logic                    busy_o,
    output logic                    done_o,
    output logic                    refused_o,
    output logic                    position_load_o,
    output logic [POS_W-1:0]        position_value_o
);

    // ************************************************
    // input conditioning
    // ************************************************
    ahs_sense_if sns ();

    ahs_sense u_sense (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .limit_neg_i   (limit_neg_i),
        .limit_pos_i   (limit_pos_i),
        .home_switch_i (home_switch_i),
        .index_i       (index_i),
        .sns           (sns)
    );

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        ahs_state_t         st;
        logic [MODE_W-1:0]  mode;
        logic [SPEED_W-1:0] spd_fast;
        logic [SPEED_W-1:0] spd_slow;
        logic [POS_W-1:0]   home_pos;
        logic [SPEED_W-1:0] speed;
        logic               dir_pos;
        logic               move;
        logic               armed;
        logic               done;
        logic               refused;
        logic               load;
        logic [POS_W-1:0]   pos_val;
    } ahs_seq_state_t;

    ahs_seq_state_t q;
    ahs_seq_state_t next_q;
    logic           idx_ok;

    // index qualifier of the slow phase
    always_comb begin
        case (q.mode)
            MODE_NEG_LIMIT: idx_ok = ~sns.lim_neg; // R04
            MODE_POS_LIMIT: idx_ok = ~sns.lim_pos; // R08
            MODE_SW_REV:    idx_ok = ~sns.home_sw; // R10 R11
            MODE_SW_SLOW:   idx_ok = q.armed;      // R12 R13
            default:        idx_ok = 1'b0;
        endcase
    end

    // ************************************************
    // sequencer
    // ************************************************
    always_comb begin
        next_q         = q;
        next_q.done    = 1'b0;
        next_q.refused = 1'b0;
        next_q.load    = 1'b0;
        case (q.st)
            AHS_IDLE: begin
                if (homing_command_i) begin
                    next_q.mode     = mode_i;          // R14
                    next_q.spd_fast = speed_fast_i;    // R14
                    next_q.spd_slow = speed_slow_i;    // R14
                    next_q.home_pos = home_position_i;
                    next_q.armed    = 1'b0;
                    next_q.move     = 1'b1;
                    case (mode_i)
                        MODE_NEG_LIMIT: begin
                            next_q.st      = sns.lim_neg ? AHS_SLOW : AHS_FAST;     // R01 R03
                            next_q.dir_pos = sns.lim_neg;                           // R01 R03
                            next_q.speed   = sns.lim_neg ? speed_slow_i : speed_fast_i;
                        end
                        MODE_POS_LIMIT: begin
                            next_q.st      = sns.lim_pos ? AHS_SLOW : AHS_FAST;     // R05 R07
                            next_q.dir_pos = ~sns.lim_pos;                          // R05 R07
                            next_q.speed   = sns.lim_pos ? speed_slow_i : speed_fast_i;
                        end
                        MODE_SW_REV, MODE_SW_SLOW: begin
                            next_q.st      = sns.home_sw ? AHS_SLOW : AHS_FAST;     // R09 R11 R12 R13
                            next_q.dir_pos = ~sns.home_sw;                          // R09 R11 R12 R13
                            next_q.speed   = sns.home_sw ? speed_slow_i : speed_fast_i;
                        end
                        default: begin
                            next_q.move    = 1'b0;
                            next_q.refused = 1'b1;
                        end
                    endcase
                end
            end
            AHS_FAST: begin
                case (q.mode)
                    MODE_NEG_LIMIT: begin
                        if (sns.lim_neg) begin
                            next_q.st      = AHS_SLOW;   // R02
                            next_q.dir_pos = 1'b1;       // R02
                            next_q.speed   = q.spd_slow; // R02
                        end
                    end
                    MODE_POS_LIMIT: begin
                        if (sns.lim_pos) begin
                            next_q.st      = AHS_SLOW;   // R06
                            next_q.dir_pos = 1'b0;       // R06
                            next_q.speed   = q.spd_slow; // R06
                        end
                    end
                    MODE_SW_REV: begin
                        if (sns.home_sw) begin
                            next_q.st      = AHS_SLOW;   // R09
                            next_q.dir_pos = 1'b0;       // R09
                            next_q.speed   = q.spd_slow; // R09
                        end
                    end
                    default: begin
                        if (sns.home_sw) begin
                            next_q.st    = AHS_SLOW;     // R12
                            next_q.speed = q.spd_slow;   // R12
                            next_q.armed = 1'b1;         // R12
                        end
                    end
                endcase
            end
            AHS_SLOW: begin
                if (sns.index_rise && idx_ok) begin
                    next_q.st      = AHS_IDLE;     // R15
                    next_q.move    = 1'b0;         // R15
                    next_q.speed   = SPEED_RST;    // R15
                    next_q.done    = 1'b1;         // R15
                    next_q.load    = 1'b1;         // R15
                    next_q.pos_val = q.home_pos;   // R15
                end else if (q.mode == MODE_SW_SLOW && !q.armed && !sns.home_sw) begin
                    next_q.dir_pos = 1'b1;         // R13
                    next_q.armed   = 1'b1;         // R13
                end
            end
            default: begin
                next_q.st   = AHS_IDLE;
                next_q.move = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q          <= '0;
            q.st       <= AHS_IDLE;
            q.mode     <= MODE_RST;
            q.speed    <= SPEED_RST;
            q.pos_val  <= POS_RST;
        end else begin
            q <= next_q;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign move_o           = q.move;
    assign dir_pos_o        = q.dir_pos;
    assign speed_o          = q.speed;
    assign busy_o           = (q.st != AHS_IDLE);
    assign done_o           = q.done;
    assign refused_o        = q.refused;
    assign position_load_o  = q.load;
    assign position_value_o = q.pos_val;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_m1_fast_start: assert property ( // R01
        q.st == AHS_IDLE && homing_command_i && mode_i == MODE_NEG_LIMIT && !sns.lim_neg
        |=> move_o && !dir_pos_o && speed_o == $past(speed_fast_i))
        else $error("mode 1 fast start wrong");
    chk_m1_reverse: assert property ( // R02
        q.st == AHS_FAST && q.mode == MODE_NEG_LIMIT && sns.lim_neg
        |=> dir_pos_o && speed_o == q.spd_slow && q.st == AHS_SLOW)
        else $error("mode 1 reversal wrong");
    chk_m1_slow_start: assert property ( // R03
        q.st == AHS_IDLE && homing_command_i && mode_i == MODE_NEG_LIMIT && sns.lim_neg
        |=> move_o && dir_pos_o && speed_o == $past(speed_slow_i))
        else $error("mode 1 slow start wrong");
    chk_m1_index_home: assert property ( // R04
        q.st == AHS_SLOW && q.mode == MODE_NEG_LIMIT && sns.index_rise
        |=> done_o == !$past(sns.lim_neg))
        else $error("mode 1 index qualification wrong");
    chk_m2_fast_start: assert property ( // R05
        q.st == AHS_IDLE && homing_command_i && mode_i == MODE_POS_LIMIT && !sns.lim_pos
        |=> move_o && dir_pos_o && speed_o == $past(speed_fast_i))
        else $error("mode 2 fast start wrong");
    chk_m2_reverse: assert property ( // R06
        q.st == AHS_FAST && q.mode == MODE_POS_LIMIT && sns.lim_pos
        |=> !dir_pos_o && speed_o == q.spd_slow)
        else $error("mode 2 reversal wrong");
    chk_m2_slow_start: assert property ( // R07
        q.st == AHS_IDLE && homing_command_i && mode_i == MODE_POS_LIMIT && sns.lim_pos
        |=> move_o && !dir_pos_o && speed_o == $past(speed_slow_i))
        else $error("mode 2 slow start wrong");
    chk_m2_index_home: assert property ( // R08
        q.st == AHS_SLOW && q.mode == MODE_POS_LIMIT && sns.index_rise
        |=> done_o == !$past(sns.lim_pos))
        else $error("mode 2 index qualification wrong");
    chk_m3_reverse: assert property ( // R09
        q.st == AHS_FAST && q.mode == MODE_SW_REV && sns.home_sw
        |=> !dir_pos_o && speed_o == q.spd_slow)
        else $error("mode 3 reversal wrong");
    chk_m3_index_home: assert property ( // R10
        q.st == AHS_SLOW && q.mode == MODE_SW_REV && sns.index_rise && sns.home_sw
        |=> !done_o && busy_o)
        else $error("mode 3 index taken with switch on");
    chk_m3_slow_start: assert property ( // R11
        q.st == AHS_IDLE && homing_command_i && mode_i == MODE_SW_REV && sns.home_sw
        |=> !dir_pos_o && speed_o == $past(speed_slow_i))
        else $error("mode 3 direct start wrong");
    chk_m4_slow_down: assert property ( // R12
        q.st == AHS_FAST && q.mode == MODE_SW_SLOW && sns.home_sw
        |=> dir_pos_o && speed_o == q.spd_slow && q.armed)
        else $error("mode 4 slow down wrong");
    chk_m4_late_reverse: assert property ( // R13
        q.st == AHS_SLOW && q.mode == MODE_SW_SLOW && !q.armed && !dir_pos_o && !sns.home_sw
        && !sns.index_rise |=> dir_pos_o && speed_o == q.spd_slow)
        else $error("mode 4 reversal wrong");
    chk_cfg_held: assert property ( // R14
        busy_o && $past(busy_o) |-> $stable(q.mode) && $stable(q.spd_fast) && $stable(q.spd_slow))
        else $error("configuration changed during homing");
    chk_home_complete: assert property ( // R15
        done_o |-> position_load_o && !move_o && !busy_o && position_value_o == q.home_pos)
        else $error("homing completion wrong");

endmodule : axis_homing_sequencer

// ---- axis_homing_sequencer_test.sv ----
// Purpose: self-checking bench of the axis homing sequencer
// Assumes: axis model steps one position per clock; switch geometry in the model
// Notes:   inputs change 2 ns after the rising edge
`timescale 1ns/10ps
module axis_homing_sequencer_test
    import ahs_pkg::*;
;

    localparam logic [SPEED_W-1:0] FAST = 16'h1234;
    localparam logic [SPEED_W-1:0] SLOW = 16'h0056;
    localparam logic [POS_W-1:0]   HOME = 32'hA5C3_0F18;

    logic               clk_i;
    logic               resetn_i;
    logic               homing_command_i;
    logic [MODE_W-1:0]  mode_i;
    logic [SPEED_W-1:0] speed_fast_i;
    logic [SPEED_W-1:0] speed_slow_i;
    logic [POS_W-1:0]   home_position_i;
    logic               limit_neg_i;
    logic               limit_pos_i;
    logic               home_switch_i;
    logic               index_i;
    logic               move_o;
    logic               dir_pos_o;
    logic [SPEED_W-1:0] speed_o;
    logic               busy_o;
    logic               done_o;
    logic               refused_o;
    logic               position_load_o;
    logic [POS_W-1:0]   position_value_o;
    int                 bad_count;
    int                 comparisons;
    int                 cycles;

    axis_homing_sequencer i_axis_homing_sequencer (
        .clk_i(clk_i), .resetn_i(resetn_i), .homing_command_i(homing_command_i), .mode_i(mode_i),
        .speed_fast_i(speed_fast_i), .speed_slow_i(speed_slow_i), .home_position_i(home_position_i),
        .limit_neg_i(limit_neg_i), .limit_pos_i(limit_pos_i), .home_switch_i(home_switch_i),
        .index_i(index_i), .move_o(move_o), .dir_pos_o(dir_pos_o), .speed_o(speed_o),
        .busy_o(busy_o), .done_o(done_o), .refused_o(refused_o),
        .position_load_o(position_load_o), .position_value_o(position_value_o)
    );

    ahs_axis_model i_ahs_axis_model (
        .clk_i(clk_i), .move_i(move_o), .dir_pos_i(dir_pos_o), .limit_neg_o(limit_neg_i),
        .limit_pos_o(limit_pos_i), .home_switch_o(home_switch_i), .index_o(index_i)
    );

    // ************************************************
    // compare and closing tasks
    // ************************************************
    task check_vec(input string name, input logic [POS_W-1:0] exp, input logic [POS_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check_vec

    task check_int(input string name, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            bad_count++;
            $display("wrong value %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_int

    task conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task next_cycle();
        @(posedge clk_i);
        #2;
    endtask : next_cycle

    // ************************************************
    // scenarios
    // ************************************************
    task home_run(input logic [MODE_W-1:0] mode, input int start, input logic dir0,
                  input logic fast0, input logic dir1, input int home_at);
        logic [SPEED_W-1:0] spd0;
        int                 n;
        spd0 = fast0 ? FAST : SLOW;
        i_ahs_axis_model.place(start);
        next_cycle();
        next_cycle();
        mode_i           = mode;
        speed_fast_i     = FAST;
        speed_slow_i     = SLOW;
        home_position_i  = HOME;
        homing_command_i = 1'b1;
        next_cycle();
        homing_command_i = 1'b0;
        check_vec("move", 32'h1, {31'h0, move_o});
        check_vec("busy", 32'h1, {31'h0, busy_o});
        check_vec("dir start", {31'h0, dir0}, {31'h0, dir_pos_o});
        check_vec("speed start", {16'h0, spd0}, {16'h0, speed_o});
        mode_i           = 4'h0;
        speed_fast_i     = 16'hFFFF;
        speed_slow_i     = 16'h0001;
        home_position_i  = 32'h0000_0000;
        homing_command_i = 1'b1;
        next_cycle();
        homing_command_i = 1'b0;
        check_vec("refused busy", 32'h0, {31'h0, refused_o});
        check_vec("speed held", {16'h0, spd0}, {16'h0, speed_o});
        if (fast0 || (dir1 !== dir0)) begin
            n = 0;
            while (dir_pos_o === dir0 && speed_o === spd0 && n < 400) begin
                next_cycle();
                n++;
            end
            check_vec("dir second", {31'h0, dir1}, {31'h0, dir_pos_o});
            check_vec("speed second", {16'h0, SLOW}, {16'h0, speed_o});
            check_vec("move second", 32'h1, {31'h0, move_o});
        end
        n = 0;
        while (done_o !== 1'b1 && n < 400) begin
            next_cycle();
            n++;
        end
        check_vec("done", 32'h1, {31'h0, done_o});
        check_vec("load", 32'h1, {31'h0, position_load_o});
        check_vec("home value", HOME, position_value_o);
        check_vec("move stop", 32'h0, {31'h0, move_o});
        check_vec("busy end", 32'h0, {31'h0, busy_o});
        check_vec("speed end", 32'h0, {16'h0, speed_o});
        check_int("home index", home_at, i_ahs_axis_model.last_index);
        next_cycle();
        check_vec("done pulse", 32'h0, {31'h0, done_o});
    endtask : home_run

    task refuse_run(input logic [MODE_W-1:0] mode);
        mode_i           = mode;
        homing_command_i = 1'b1;
        next_cycle();
        homing_command_i = 1'b0;
        check_vec("refused", 32'h1, {31'h0, refused_o});
        check_vec("busy refused", 32'h0, {31'h0, busy_o});
        check_vec("move refused", 32'h0, {31'h0, move_o});
        next_cycle();
    endtask : refuse_run

    // ************************************************
    // clock, reset and sequence
    // ************************************************
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        bad_count        = 0;
        comparisons      = 0;
        cycles           = 0;
        resetn_i         = 1'b0;
        homing_command_i = 1'b0;
        mode_i           = 4'h0;
        speed_fast_i     = 16'h0000;
        speed_slow_i     = 16'h0000;
        home_position_i  = 32'h0000_0000;
        repeat (16) next_cycle();
        resetn_i = 1'b1;
        check_vec("busy reset", 32'h0, {31'h0, busy_o});
        home_run(4'h1, 50, 1'b0, 1'b1, 1'b1, 8);
        home_run(4'h1, -10, 1'b1, 1'b0, 1'b1, 8);
        home_run(4'h2, 150, 1'b1, 1'b1, 1'b0, 184);
        home_run(4'h2, 210, 1'b0, 1'b0, 1'b0, 184);
        home_run(4'h3, 60, 1'b1, 1'b1, 1'b0, 88);
        home_run(4'h3, 110, 1'b0, 1'b0, 1'b0, 88);
        home_run(4'h4, 60, 1'b1, 1'b1, 1'b1, 104);
        home_run(4'h4, 110, 1'b0, 1'b0, 1'b1, 104);
        refuse_run(4'h0);
        refuse_run(4'h5);
        conclude();
    end
endmodule : axis_homing_sequencer_test
